// ### design/afc_pkg.sv
// afc_pkg: constants for the fifo host controller
// assumes a 100 MHz pclk and an apb register port
package afc_pkg;
	localparam int          PCLK_MHZ       = 100;
	localparam int          DATA_W         = 9;
	// pin timing in ns, fastest grade
	localparam int          T_PULSE_NS     = 35;
	localparam int          T_RECOV_NS     = 10;
	localparam int          T_SETUP_NS     = 35;
	localparam int          T_FLAG_NS      = 45;
	localparam int          PULSE_CYC      = (T_PULSE_NS * PCLK_MHZ + 999) / 1000;
	localparam int          RECOV_CYC      = (T_RECOV_NS * PCLK_MHZ + 999) / 1000;
	localparam int          SETUP_CYC      = (T_SETUP_NS * PCLK_MHZ + 999) / 1000;
	localparam int          FLAG_CYC       = (T_FLAG_NS * PCLK_MHZ + 999) / 1000;
	// register byte addresses
	localparam logic [11:0] ADDR_CTRL      = 12'h000;
	localparam logic [11:0] ADDR_STATUS    = 12'h004;
	localparam logic [11:0] ADDR_WDATA     = 12'h008;
	localparam logic [11:0] ADDR_RDATA     = 12'h00C;
	// ctrl fields (write 1 to bits 0-3 to start an operation; chain and first set the mode)
	localparam int          CTRL_WRITE     = 0;
	localparam int          CTRL_READ      = 1;
	localparam int          CTRL_RESET     = 2;
	localparam int          CTRL_REPLAY    = 3;
	localparam int          CTRL_CHAIN     = 4;
	localparam int          CTRL_FIRST     = 5;
	// status fields
	localparam int          ST_BUSY        = 0;
	localparam int          ST_EMPTY       = 1;
	localparam int          ST_FULL        = 2;
	localparam int          ST_HALF        = 3;
	localparam int          ST_RVALID      = 4;
	localparam int          ST_REFUSED     = 5;
	localparam logic [1:0]  CFG_RESET_VAL  = 2'h0;
	typedef enum logic [2:0]
	{
		AFC_IDLE   = 3'b000,
		AFC_SETUP  = 3'b001,
		AFC_PULSE  = 3'b010,
		AFC_WAIT   = 3'b011,
		AFC_RECOV  = 3'b100
	} afc_state_t;
	typedef enum logic [1:0]
	{
		AFC_OP_WR  = 2'b00,
		AFC_OP_RD  = 2'b01,
		AFC_OP_RST = 2'b10,
		AFC_OP_RT  = 2'b11
	} afc_op_t;
endpackage : afc_pkg

// ### design/afc_cnt.sv
// afc_cnt: loadable down counter used for pulse and gap timing
// assumes load and count requests are mutually exclusive per cycle
`timescale 1ns/1ps
module afc_cnt #(
	parameter int W = 4
) (
	// clock and reset
	input  wire logic         pclk,
	input  wire logic         presetn,
	// control
	input  wire logic         load,
	input  wire logic [W-1:0] value,
	// status
	output logic              done
);
	logic [W-1:0] cnt_q;

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			cnt_q <= '0;
		else if (load)
			cnt_q <= value;
		else if (cnt_q != '0)
			cnt_q <= cnt_q - 1'b1;
	end

	assign done = (cnt_q == '0);
endmodule : afc_cnt

// ### design/afc_sync_hold.sv
// afc_sync_hold: samples the data bus while the read strobe is low
// assumes the bus is driven by the fifo during the read pulse
`timescale 1ns/1ps
module afc_sync_hold #(
	parameter int W = 9
) (
	// clock and reset
	input  wire logic         pclk,
	input  wire logic         presetn,
	// capture
	input  wire logic         capture,
	input  wire logic [W-1:0] din,
	output logic [W-1:0]      dout
);
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			dout <= '0;
		else if (capture)
			dout <= din;
	end
endmodule : afc_sync_hold

// ### design/afc_host.sv
// afc_host: apb controlled host that drives an asynchronous 9-bit fifo
// assumes fifo pins are synchronous to pclk; data bus is split into wdata and rdata
// Overview of operation
// - single device: chain input held low by the host
// - width expansion: all buffers share the same strobes and modes
// - never tie flag outputs of separate buffers together
// - first buffer of a depth chain gets first select low
// - other chained buffers hold first select high
// - chain output of each buffer feeds chain input of next
// - host combines full flags and empty flags of chain
// - watch full of written buffer, empty of read buffer; host waits on any_full and any_empty of all buffers instead
// - width and depth expansion may be combined
// - write, reset and replay pulses never shorter than minimum
// - pending read held full width after empty releases
// - pending write held full width after full releases
// - strobes high for setup before replay, recovery after
// - reset returns pointers; strobes stay high during reset
//
// Design decisions made here: register access over APB and the placing of the registers.
`timescale 1ns/1ps
module afc_host
	import afc_pkg::*;
#(
	parameter int N_DEV = 1
) (
	// apb slave
	input  wire logic                    pclk,
	input  wire logic                    presetn,
	input  wire logic                    psel,
	input  wire logic                    penable,
	input  wire logic                    pwrite,
	input  wire logic [11:0]             paddr,
	input  wire logic [31:0]             pwdata,
	output logic      [31:0]             prdata,
	output logic                         pready,
	output logic                         pslverr,
	// fifo strobes, shared by every buffer; then the chain and first select mode pins
	output logic                         write_strobe_n,
	output logic                         read_strobe_n,
	output logic                         reset_n,
	output logic                         replay_strobe_n,
	output logic                         chain_in_n,
	output logic                         first_device_select_n,
	// fifo data
	output logic      [afc_pkg::DATA_W-1:0] wdata,
	input  wire logic [afc_pkg::DATA_W-1:0] rdata,
	// fifo flags, one per buffer
	input  wire logic [N_DEV-1:0]        empty_flag_n,
	input  wire logic [N_DEV-1:0]        full_flag_n,
	input  wire logic [N_DEV-1:0]        half_full_flag_n
);
	import afc_pkg::*;

	////////////////////////////////////////////////////////////////////
	afc_state_t             state_q;
	afc_op_t                op_q;
	logic [1:0]             cfg_q;
	logic [DATA_W-1:0]      wdata_q;
	logic                   rvalid_q;
	logic                   refused_q;
	logic                   any_empty;
	logic                   any_full;
	logic                   any_half;
	logic                   cnt_load;
	logic [3:0]             cnt_val;
	logic                   cnt_done;
	logic [DATA_W-1:0]      rd_hold;
	logic                   wr_acc;
	logic                   rd_acc;
	logic                   start;
	afc_op_t                start_op;

	// empty and full flags of each buffer kept on their own nets, combined here; half full from buffer 0 only
	assign any_empty = ~&empty_flag_n;
	assign any_full  = ~&full_flag_n;
	assign any_half  = cfg_q[0] ? 1'b0 : ~half_full_flag_n[0];

	assign wr_acc = psel & penable & pwrite & pready;
	assign rd_acc = psel & penable & ~pwrite & pready;

	////////////////////////////////////////////////////////////////////
	// apb: one wait-free access; unmapped reads zero, error flagged only above 0x00F
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			pready <= 1'b0;
		else
			pready <= psel & ~penable;
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			pslverr <= 1'b0;
		else
			pslverr <= psel & ~penable & (paddr[11:4] != 8'h00);
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			prdata <= 32'h0000_0000;
		else if (psel & ~penable & ~pwrite)
		begin
			case (paddr)
				ADDR_CTRL:   prdata <= {26'h0, cfg_q, 4'h0};
				ADDR_STATUS: prdata <= {26'h0, refused_q, rvalid_q,
					any_half, any_full, any_empty,
					(state_q != AFC_IDLE)};
				ADDR_WDATA:  prdata <= {23'h0, wdata_q};
				ADDR_RDATA:  prdata <= {23'h0, rd_hold};
				default:     prdata <= 32'h0000_0000;
			endcase
		end
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			wdata_q <= '0;
		else if (wr_acc && paddr == ADDR_WDATA)
			wdata_q <= pwdata[DATA_W-1:0];
	end

	// mode bits freeze while busy so a running pulse is never cut short
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			cfg_q <= CFG_RESET_VAL;
		else if (wr_acc && paddr == ADDR_CTRL && state_q == AFC_IDLE)
			cfg_q <= {pwdata[CTRL_FIRST], pwdata[CTRL_CHAIN]};
	end

	// one command per ctrl write, lowest bit wins; ignored while busy
	always_comb
	begin
		start    = 1'b0;
		start_op = AFC_OP_WR;
		if (wr_acc && paddr == ADDR_CTRL && state_q == AFC_IDLE)
		begin
			start = |pwdata[3:0];
			if (pwdata[CTRL_WRITE])
				start_op = AFC_OP_WR;
			else if (pwdata[CTRL_READ])
				start_op = AFC_OP_RD;
			else if (pwdata[CTRL_RESET])
				start_op = AFC_OP_RST;
			else
				start_op = AFC_OP_RT;
		end
	end

	////////////////////////////////////////////////////////////////////
	// pin sequencer
	afc_cnt #(
		.W (4)
	) u_cnt (
		.pclk    (pclk),
		.presetn (presetn),
		.load    (cnt_load),
		.value   (cnt_val),
		.done    (cnt_done)
	);

	afc_sync_hold #(
		.W (DATA_W)
	) u_hold (
		.pclk    (pclk),
		.presetn (presetn),
		.capture (state_q == AFC_PULSE && op_q == AFC_OP_RD && cnt_done),
		.din     (rdata),
		.dout    (rd_hold)
	);

	always_comb
	begin
		cnt_load = 1'b0;
		cnt_val  = 4'h0;
		case (state_q)
			AFC_IDLE:
				if (start)
				begin
					cnt_load = 1'b1;
					cnt_val  = 4'(SETUP_CYC);
				end
			AFC_SETUP:
				if (cnt_done)
				begin
					cnt_load = 1'b1;
					cnt_val  = 4'(PULSE_CYC);
				end
			AFC_WAIT:
				if (!(op_q == AFC_OP_RD ? any_empty : any_full))
				begin
					// full width again once flag releases
					cnt_load = 1'b1;
					cnt_val  = 4'(PULSE_CYC);
				end
			AFC_PULSE:
				if (cnt_done)
				begin
					cnt_load = 1'b1;
					cnt_val  = (op_q == AFC_OP_RST) ? 4'(FLAG_CYC)
						: 4'(RECOV_CYC);
				end
			default: ;
		endcase
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			state_q <= AFC_IDLE;
		else
		begin
			case (state_q)
				AFC_IDLE:
					if (start)
						state_q <= AFC_SETUP;
				AFC_SETUP:
					if (cnt_done)
					begin
						if ((op_q == AFC_OP_RD && any_empty) ||
							(op_q == AFC_OP_WR && any_full))
							state_q <= AFC_WAIT;
						else
							state_q <= AFC_PULSE;
					end
				AFC_WAIT:
					if (!(op_q == AFC_OP_RD ? any_empty : any_full))
						state_q <= AFC_PULSE;
				AFC_PULSE:
					if (cnt_done)
						state_q <= AFC_RECOV;
				AFC_RECOV:
					if (cnt_done)
						state_q <= AFC_IDLE;
				default:
					state_q <= AFC_IDLE;
			endcase
		end
	end

	// op latched with the start so the sequencer sees one stable command
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			op_q <= AFC_OP_WR;
		else if (start)
			op_q <= start_op;
	end

	// a replay in chain mode is refused: the buffers lack it
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			refused_q <= 1'b0;
		else if (start)
			refused_q <= (start_op == AFC_OP_RT) && cfg_q[0];
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			rvalid_q <= 1'b0;
		// a new word wins over a clear landing in the same cycle
		else if (state_q == AFC_PULSE && op_q == AFC_OP_RD && cnt_done)
			rvalid_q <= 1'b1;
		else if (rd_acc && paddr == ADDR_RDATA)
			rvalid_q <= 1'b0;
	end

	////////////////////////////////////////////////////////////////////
	// pin drivers: strobes stay high outside their own pulse
	// each strobe comes straight off its own flop, so no glitch reaches
	// the buffers while the sequencer changes state
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			write_strobe_n <= 1'b1;
		else
			write_strobe_n <= !(state_q == AFC_PULSE &&
				op_q == AFC_OP_WR && !cnt_done);
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			read_strobe_n <= 1'b1;
		else
			read_strobe_n <= !(state_q == AFC_PULSE &&
				op_q == AFC_OP_RD && !cnt_done);
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			reset_n <= 1'b1;
		else
			reset_n <= !(state_q == AFC_PULSE &&
				op_q == AFC_OP_RST && !cnt_done);
	end

	// chained buffers have no replay, so the pulse is withheld there
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			replay_strobe_n <= 1'b1;
		else
			replay_strobe_n <= !(state_q == AFC_PULSE &&
				op_q == AFC_OP_RT && !cnt_done && !cfg_q[0]);
	end

	// chain mode: chain_in released (fed by previous chain_out on board)
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			chain_in_n <= 1'b0;
		else
			chain_in_n <= cfg_q[0];
	end

	// first select idles high so a single buffer never sees it move
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			first_device_select_n <= 1'b1;
		else
			first_device_select_n <= cfg_q[0] ? ~cfg_q[1]
				: 1'b1;
	end

	// write data follows the register one cycle later, also while a pulse runs
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			wdata <= '0;
		else
			wdata <= wdata_q;
	end
endmodule : afc_host

// ### tb/afc_fifo_model.sv
// afc_fifo_model: behavioural 9-bit strobe fifo on the host's pins
// assumes strobes from afc_host; flags settle after FLAG_DLY ns
`timescale 1ns/1ps
module afc_fifo_model #(
	parameter int DEPTH    = 8,
	parameter int FLAG_DLY = 20
) (
	// strobes and mode
	input  wire logic                   write_strobe_n,
	input  wire logic                   read_strobe_n,
	input  wire logic                   reset_n,
	input  wire logic                   replay_strobe_n,
	input  wire logic                   chain_in_n,
	// data
	input  wire logic [afc_pkg::DATA_W-1:0] wdata,
	output logic      [afc_pkg::DATA_W-1:0] rdata,
	// flags
	output logic                        empty_flag_n,
	output logic                        full_flag_n,
	output logic                        half_full_flag_n,
	// expansion
	output logic                        chain_out_n
);
	import afc_pkg::*;
	logic [DATA_W-1:0] mem [DEPTH];
	int                wp = 0;
	int                rp = 0;
	int                cnt = 0;
	bit                w_act = 0;
	bit                r_act = 0;
	bit                xo_evt = 0;
	//////////////////////////////////////////////////////////////////////
	always @(negedge reset_n)
	begin
		wp = 0;
		rp = 0;
		cnt = 0;
	end
	// a strobe falling on a full or empty array stays ignored till it rises
	always @(negedge write_strobe_n)
		w_act = reset_n && cnt < DEPTH;
	always @(posedge write_strobe_n)
	begin
		if (w_act)
		begin
			mem[wp] = wdata;
			wp = (wp + 1) % DEPTH;
			cnt++;
			if (chain_in_n && wp == 0)
				xo_evt = ~xo_evt;
		end
		w_act = 0;
	end
	always @(negedge read_strobe_n)
		r_act = reset_n && cnt > 0;
	always @(posedge read_strobe_n)
	begin
		if (r_act)
		begin
			rp = (rp + 1) % DEPTH;
			cnt--;
			if (chain_in_n && rp == 0)
				xo_evt = ~xo_evt;
		end
		r_act = 0;
	end
	// count is rebuilt from the write pointer: valid only before it wraps
	always @(negedge replay_strobe_n)
		if (!chain_in_n)
		begin
			rp = 0;
			cnt = wp;
		end
	// token pulse to the next buffer once the last location is used
	initial chain_out_n = 1'b1;
	always @(xo_evt)
	begin
		chain_out_n = 1'b0;
		#(FLAG_DLY) chain_out_n = 1'b1;
	end
	//////////////////////////////////////////////////////////////////////
	// flags follow only the shared strobes, so width copies agree
	assign #(FLAG_DLY) empty_flag_n = (cnt - r_act) != 0;
	assign #(FLAG_DLY) full_flag_n = (cnt + w_act) != DEPTH;
	assign #(FLAG_DLY) half_full_flag_n = chain_in_n
		|| (cnt + w_act) <= DEPTH / 2;
	// a released bus shows the inverse, never a held word
	assign rdata = r_act ? mem[rp] : ~mem[rp];
endmodule : afc_fifo_model

// ### tb/afc_props.sv
// afc_props: pin timing checks on afc_host
// assumes the single pclk domain of afc_host
`timescale 1ns/1ps
module afc_props #(
	parameter int N_DEV = 1
) (
	// clock and reset
	input wire logic             pclk,
	input wire logic             presetn,
	// strobes
	input wire logic             write_strobe_n,
	input wire logic             read_strobe_n,
	input wire logic             reset_n,
	input wire logic             replay_strobe_n,
	input wire logic             chain_in_n,
	// flags
	input wire logic [N_DEV-1:0] empty_flag_n,
	input wire logic [N_DEV-1:0] full_flag_n
);
	default clocking @(posedge pclk);
	endclocking
	default disable iff (!presetn);
	logic [3:0] quiet_q;
	// edges with both data strobes high, saturating
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			quiet_q <= 4'h0;
		else if (!write_strobe_n || !read_strobe_n)
			quiet_q <= 4'h0;
		else if (quiet_q != 4'hF)
			quiet_q <= quiet_q + 4'h1;
	end
	//////////////////////////////////////////////////////////////////////
	a_wr_width : assert property (
		$fell(write_strobe_n) |-> (!write_strobe_n) [*4])
		else $error("short write");
	a_rd_width : assert property (
		$fell(read_strobe_n) |-> (!read_strobe_n) [*4])
		else $error("short read");
	a_rst_width : assert property (
		$fell(reset_n) |-> (!reset_n) [*4])
		else $error("short reset");
	a_rt_width : assert property (
		$fell(replay_strobe_n) |-> (!replay_strobe_n) [*4])
		else $error("short replay");
	a_rst_quiet : assert property (
		!reset_n |-> write_strobe_n && read_strobe_n)
		else $error("strobe during reset");
	a_rt_setup : assert property (
		$fell(replay_strobe_n) |-> quiet_q >= 4'h4)
		else $error("replay setup short");
	a_rt_recov : assert property (
		$rose(replay_strobe_n) |-> (write_strobe_n && read_strobe_n) [*2])
		else $error("replay recovery short");
	a_wr_on_full : assert property (
		$fell(write_strobe_n) |-> &$past(full_flag_n))
		else $error("write while full");
	a_rd_on_empty : assert property (
		$fell(read_strobe_n) |-> &$past(empty_flag_n))
		else $error("read while empty");
	a_chain_no_rt : assert property (
		chain_in_n |-> replay_strobe_n)
		else $error("replay in chain mode");
endmodule : afc_props
bind afc_host afc_props #(.N_DEV(N_DEV)) u_afc_props (
	.pclk(pclk), .presetn(presetn), .write_strobe_n(write_strobe_n),
	.read_strobe_n(read_strobe_n), .reset_n(reset_n),
	.replay_strobe_n(replay_strobe_n), .chain_in_n(chain_in_n),
	.empty_flag_n(empty_flag_n), .full_flag_n(full_flag_n));

// ### tb/tb_top.sv
// tb_top: apb bench for afc_host with a fifo model
// assumes the afc_pkg register map
`timescale 1ns/1ps
module tb_top;
	import afc_pkg::*;
	localparam int DEPTH = 8;
	typedef struct {logic rd; logic [8:0] d; logic [8:0] st;} afc_row_t;
	afc_row_t    rows [2*DEPTH];
	logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, q;
	logic [31:0] mode = 32'h0;
	logic        wr_n, rd_n, rs_n, rt_n, ci_n, fs_n, ef_n, ff_n, hf_n;
	logic        co_n;
	logic [8:0]  wd, rdw;
	int          fails = 0;
	int          total_checks = 0;
	int          c = 0;
	int          xo_seen = 0;
	initial
	begin
		pclk = 1'b0;
		forever #5 pclk = ~pclk;
	end
	afc_host u_afc_host (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr),
		.write_strobe_n(wr_n), .read_strobe_n(rd_n), .reset_n(rs_n),
		.replay_strobe_n(rt_n), .chain_in_n(ci_n),
		.first_device_select_n(fs_n), .wdata(wd), .rdata(rdw),
		.empty_flag_n(ef_n), .full_flag_n(ff_n), .half_full_flag_n(hf_n));
	afc_fifo_model #(.DEPTH(DEPTH)) u_afc_fifo_model (.write_strobe_n(wr_n),
		.read_strobe_n(rd_n), .reset_n(rs_n), .replay_strobe_n(rt_n),
		.chain_in_n(ci_n), .wdata(wd), .rdata(rdw), .empty_flag_n(ef_n),
		.full_flag_n(ff_n), .half_full_flag_n(hf_n), .chain_out_n(co_n));
	// token pulses from the model, counted for the chain test
	always @(negedge co_n)
		xo_seen++;
	//////////////////////////////////////////////////////////////////////
	task automatic check(input logic [8:0] seen, input logic [8:0] exp);
		total_checks++;
		if (seen !== exp)
		begin
			fails++;
			$display("[ERR] %0t seen %h exp %h", $time, seen, exp);
		end
	endtask : check
	task automatic tally_and_finish;
		$display("checks %0d mismatches %0d", total_checks, fails);
		if (fails == 0 && total_checks > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask : tally_and_finish
	// answer is taken from the cycle whose rising edge samples pready
	task automatic apb(input logic w, input logic [11:0] a,
		input logic [31:0] d);
		int n;
		n = 0;
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do
		begin
			@(posedge pclk);
			n++;
		end
		while (pready !== 1'b1 && n < 20);
		q = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		check(9'(n >= 20), 9'h0);
		if (n >= 20)
			tally_and_finish;
		@(posedge pclk);
	endtask : apb
	// command, wait until idle, let the flags settle, leave status in q
	task automatic op(input logic [31:0] cmd);
		int n;
		n = 0;
		apb(1'b1, ADDR_CTRL, cmd | mode);
		do
		begin
			apb(1'b0, ADDR_STATUS, 32'h0);
			n++;
		end
		while (q[ST_BUSY] !== 1'b0 && n < 50);
		check(9'(n >= 50), 9'h0);
		if (n >= 50)
			tally_and_finish;
		repeat (FLAG_CYC) @(posedge pclk);
		apb(1'b0, ADDR_STATUS, 32'h0);
	endtask : op
	task automatic wr_word(input logic [8:0] d);
		apb(1'b1, ADDR_WDATA, {23'h0, d});
		op(32'h1);
	endtask : wr_word
	task automatic rd_word(output logic [8:0] st);
		op(32'h2);
		st = q[8:0] & 9'h00F;
		check(q[8:0] & 9'h010, 9'h010);
		apb(1'b0, ADDR_RDATA, 32'h0);
	endtask : rd_word
	//////////////////////////////////////////////////////////////////////
	initial
	begin
		logic [8:0] st;
		presetn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 12'h000;
		pwdata = 32'h0;
		foreach (rows[i])
		begin
			rows[i].rd = i >= DEPTH;
			rows[i].d = 9'(9'h0A5 + i * 37);
			c = rows[i].rd ? c - 1 : c + 1;
			rows[i].st = {5'h0, c > DEPTH / 2, c == DEPTH, c == 0, 1'b0};
		end
		repeat (6) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		check({7'h0, ci_n, fs_n}, 9'h001);
		apb(1'b0, ADDR_CTRL, 32'h0);
		check(q[8:0], 9'h000);
		op(32'h4);
		check(q[8:0] & 9'h00F, 9'h002);
		$display("reset test done");
		foreach (rows[i])
		begin
			if (rows[i].rd)
			begin
				rd_word(st);
				check(st, rows[i].st);
				check(q[8:0], rows[i - DEPTH].d);
			end
			else
			begin
				wr_word(rows[i].d);
				check(q[8:0] & 9'h00F, rows[i].st);
			end
		end
		$display("row test done");
		wr_word(9'h1FF);
		op(32'h4);
		check(q[8:0] & 9'h00F, 9'h002);
		for (int k = 0; k < 3; k++)
			wr_word(9'(9'h101 + k));
		rd_word(st);
		op(32'h8);
		for (int k = 0; k < 3; k++)
		begin
			rd_word(st);
			check(q[8:0], 9'(9'h101 + k));
		end
		check(st, 9'h002);
		$display("replay test done");
		mode = 32'h30;
		op(32'h0);
		check({7'h0, ci_n, fs_n}, 9'h002);
		apb(1'b0, ADDR_CTRL, 32'h0);
		check(q[8:0], 9'h030);
		op(32'h8);
		check(q[8:0] & 9'h020, 9'h020);
		for (int k = 0; k < 5; k++)
			wr_word(9'(k));
		check(9'(xo_seen), 9'h001);
		mode = 32'h10;
		op(32'h0);
		check({7'h0, ci_n, fs_n}, 9'h003);
		presetn <= 1'b0;
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		check({7'h0, ci_n, fs_n}, 9'h001);
		apb(1'b0, ADDR_CTRL, 32'h0);
		check(q[8:0], 9'h000);
		mode = 32'h0;
		op(32'h0);
		check({7'h0, ci_n, fs_n}, 9'h001);
		apb(1'b0, 12'h010, 32'h0);
		check({8'h0, err}, 9'h001);
		$display("mode test done");
		tally_and_finish;
	end
endmodule : tb_top
